// >>> gpio_extender.sv
// Notes on behaviour
// - Two-bit function per port: alternate input, general input, open-drain or push-pull.
// - Polarity bit 0: input active low; output on supply one, pull-up if open-drain.
// - General inputs are monitored continuously in every operating mode.
// - Input status follows pin directly, or through the debounce filter when enabled.
// - Edge into active level sets event flag; unmasked flags pull interrupt low.
// - Inputs 0, 3-11, 13-15 raise wake-up on activation when debouncing is on.
// - Input 12, debounce off, drives regulator nine enable, held at least 100 us.
// - Inputs 1 and 2 likewise drive regulator four and five enables.
// - Sequencer wait step stalls until input 10 turns active, then releases.
// - Polarity and supply selection also apply to alternate functions.
// - Level/debounce bit also enables wake-up from alternate functions.
// - Analog threshold crossing on port 1 alternate sets port 1 event flag.
// - Output ports drive the level of their level/debounce bit.
// - Outputs 10 and 11 can flash under the real-time-clock timer.
// - Outputs 14, 15 have PWM; brightness ramps one step every 32 ms.
// - Level/debounce bit 0: debounce off, drive low; 1: debounce on, drive high.
`include "gpio_extender_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module gpio_extender #(
	parameter int unsigned REG_MIN_ON_CYCLES = `REG_MIN_ON_US * `CLK_MHZ,
	parameter int unsigned RAMP_STEP_CYCLES = `RAMP_STEP_MS * `CLK_KHZ
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register bus
	input wire gpio_extender_pkg::apbReq_t apbReq,
	output gpio_extender_pkg::apbRsp_t apbRsp,
	// Port pins
	input wire logic [15:0] pinIn,
	output logic [15:0] pinOut,
	output logic [15:0] pinOe,
	output logic [15:0] pullUpEnable,
	output logic [15:0] supplyTwoSelect,
	// Alternate functions and timers
	input wire logic [15:0] altLevel,
	input wire logic analogBThresholdCross,
	input wire logic rtcFlash,
	// System side
	input wire logic seqWaitRequest,
	output logic seqWaitRelease,
	output logic wakeUp,
	output logic regulatorFourEnable,
	output logic regulatorFiveEnable,
	output logic regulatorNineEnable,
	output logic interruptRequestN
);
	import gpio_extender_pkg::*;

	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam int unsigned DEB_LAST = `DEBOUNCE_CYCLES - 1;
	localparam int unsigned REG_LAST = REG_MIN_ON_CYCLES - 1;
	localparam int unsigned RAMP_LAST = RAMP_STEP_CYCLES - 1;
	localparam logic [15:0] WAKE_MASK = `WAKE_PORTS;

	logic [7:0] cfgReg [8];
	logic [15:0] maskReg;
	logic [3:0] outCtrlReg;
	logic [7:0] pwmTargetReg [2];
	logic [7:0] pwmLevelReg [2];
	logic [7:0] pwmCntReg;
	logic [31:0] rampCntReg;
	logic [15:0] statusReg;
	logic [15:0] statusNext;
	logic [15:0] activePrevReg;
	logic [15:0] eventReg;
	logic [15:0] eventNext;
	logic [15:0] debCntReg [16];
	logic [15:0] debCntNext [16];
	logic [32:0] syncOneReg;
	logic [32:0] syncTwoReg;
	regState_t regStateReg [3];
	regState_t regStateNext [3];
	logic [31:0] regCntReg [3];
	logic [31:0] regCntNext [3];
	portCfg_t cfg [16];
	logic [15:0] isInput;
	logic [15:0] isAlt;
	logic [15:0] isOutput;
	logic [15:0] monLevel;
	logic [15:0] active;
	logic [15:0] rise;
	logic [15:0] wakeable;
	logic [15:0] drive;
	logic [15:0] pinOutNext;
	logic [15:0] pinOeNext;
	logic [2:0] regRequest;
	logic [31:0] readData;
	logic addrHit;
	logic rampTick;

	wire logic [15:0] pinSync = syncTwoReg[15:0];
	wire logic [15:0] altSync = syncTwoReg[31:16];
	wire logic flashSync = syncTwoReg[32];
	wire logic [5:0] regIdx = apbReq.paddr[7:2];
	wire logic setupPhase = apbReq.psel & ~apbReq.penable;
	wire logic accessDone = apbReq.psel & apbReq.penable & apbRsp.pready;
	wire logic wrEn = accessDone & apbReq.pwrite;
	wire logic [15:0] clearMask = (wrEn && regIdx == `IDX_EVENT_CLEAR) ?
		apbReq.pwdata[15:0] : 16'h0000;

	// Nibble of the port pair register that belongs to a port
	function automatic portCfg_t portCfgOf(input logic [7:0] pair, input int port);
		portCfgOf = (port % 2 == 1) ? portCfg_t'(pair[7:4]) : portCfg_t'(pair[3:0]);
	endfunction

	// Move a brightness one step toward its target
	function automatic logic [7:0] stepToward(input logic [7:0] cur, input logic [7:0] tgt);
		if (cur < tgt) begin
			stepToward = cur + 8'h01;
		end else if (cur > tgt) begin
			stepToward = cur - 8'h01;
		end else begin
			stepToward = cur;
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			syncOneReg <= '0;
			syncTwoReg <= '0;
		end else begin
			syncOneReg <= {rtcFlash, altLevel, pinIn};
			syncTwoReg <= syncOneReg;
		end
	end

	// ----------------------------------------
	// Port decode and input path
	// ----------------------------------------
	// Per-port classification, filter and edge detection
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			cfg[i] = portCfgOf(cfgReg[i / 2], i);
			isInput[i] = cfg[i].pinFunctionSelect == FUNC_INPUT;
			isAlt[i] = cfg[i].pinFunctionSelect == FUNC_ALT;
			isOutput[i] = cfg[i].pinFunctionSelect[1];
			monLevel[i] = isInput[i] ? pinSync[i] : altSync[i];
			debCntNext[i] = 16'h0000;
			statusNext[i] = statusReg[i];
			if (isOutput[i]) begin
				statusNext[i] = statusReg[i];
			end else if (!cfg[i].levelDebounceSelect) begin
				statusNext[i] = monLevel[i];
			end else if (monLevel[i] != statusReg[i]) begin
				if (debCntReg[i] == DEB_LAST[15:0]) begin
					statusNext[i] = monLevel[i];
				end else begin
					debCntNext[i] = debCntReg[i] + 16'h0001;
				end
			end
			// Polarity applies to alternate functions too
			active[i] = ~isOutput[i] &
				(statusReg[i] == cfg[i].polaritySupplySelect);
			rise[i] = active[i] & ~activePrevReg[i];
			wakeable[i] = cfg[i].levelDebounceSelect &
				((isInput[i] & WAKE_MASK[i]) | isAlt[i]);
		end
	end

	// Event flags: a new event wins over a clear in the same cycle
	always_comb begin
		eventNext = (eventReg & ~clearMask) | rise;
		if (isAlt[1] && analogBThresholdCross) begin
			eventNext[1] = 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			statusReg <= '0;
			activePrevReg <= '1; // No false edge on ports active at reset
			eventReg <= '0;
			debCntReg <= '{default: '0};
		end else begin
			statusReg <= statusNext;
			activePrevReg <= active;
			eventReg <= eventNext;
			debCntReg <= debCntNext;
		end
	end

	// ----------------------------------------
	// Regulator enables with minimum on time
	// ----------------------------------------
	// Hardware control only with debouncing off
	assign regRequest[0] = isInput[`PORT_REG_FOUR] &
		~cfg[`PORT_REG_FOUR].levelDebounceSelect & active[`PORT_REG_FOUR];
	assign regRequest[1] = isInput[`PORT_REG_FIVE] &
		~cfg[`PORT_REG_FIVE].levelDebounceSelect & active[`PORT_REG_FIVE];
	assign regRequest[2] = isInput[`PORT_REG_NINE] &
		~cfg[`PORT_REG_NINE].levelDebounceSelect & active[`PORT_REG_NINE];

	// Hold the enable for the minimum time even if the request drops
	always_comb begin
		for (int k = 0; k < 3; k++) begin
			regStateNext[k] = regStateReg[k];
			regCntNext[k] = regCntReg[k];
			case (regStateReg[k])
				REG_OFF: begin
					if (regRequest[k]) begin
						regStateNext[k] = REG_MIN;
						regCntNext[k] = REG_LAST;
					end
				end
				REG_MIN: begin
					if (regCntReg[k] != 32'h0000_0000) begin
						regCntNext[k] = regCntReg[k] - 32'h0000_0001;
					end else if (regRequest[k]) begin
						regStateNext[k] = REG_ON;
					end else begin
						regStateNext[k] = REG_OFF;
					end
				end
				REG_ON: begin
					if (!regRequest[k]) begin
						regStateNext[k] = REG_OFF;
					end
				end
				default: begin
					regStateNext[k] = REG_OFF;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regStateReg <= '{default: REG_OFF};
			regCntReg <= '{default: '0};
			regulatorFourEnable <= 1'b0;
			regulatorFiveEnable <= 1'b0;
			regulatorNineEnable <= 1'b0;
		end else begin
			regStateReg <= regStateNext;
			regCntReg <= regCntNext;
			regulatorFourEnable <= regStateNext[0] != REG_OFF;
			regulatorFiveEnable <= regStateNext[1] != REG_OFF;
			regulatorNineEnable <= regStateNext[2] != REG_OFF;
		end
	end

	// ----------------------------------------
	// PWM ramp for outputs 14 and 15
	// ----------------------------------------
	assign rampTick = rampCntReg == RAMP_LAST;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			rampCntReg <= '0;
			pwmCntReg <= '0;
			pwmLevelReg <= '{default: '0};
		end else begin
			rampCntReg <= rampTick ? 32'h0000_0000 : rampCntReg + 32'h0000_0001;
			pwmCntReg <= pwmCntReg + 8'h01;
			if (rampTick) begin
				pwmLevelReg[0] <= stepToward(pwmLevelReg[0], pwmTargetReg[0]);
				pwmLevelReg[1] <= stepToward(pwmLevelReg[1], pwmTargetReg[1]);
			end
		end
	end

	// ----------------------------------------
	// Output drive
	// ----------------------------------------
	// Level bit, optionally gated by flashing or replaced by PWM
	always_comb begin
		for (int i = 0; i < 16; i++) begin
			drive[i] = cfg[i].levelDebounceSelect;
		end
		for (int f = 0; f < 2; f++) begin
			if (outCtrlReg[`OUT_CTRL_FLASH_LSB + f]) begin
				drive[`PORT_FLASH_LO + f] = cfg[`PORT_FLASH_LO + f].levelDebounceSelect &
					flashSync;
			end
			if (outCtrlReg[`OUT_CTRL_PWM_LSB + f]) begin
				drive[`PORT_PWM_LO + f] = pwmLevelReg[f] > pwmCntReg;
			end
		end
		for (int i = 0; i < 16; i++) begin
			pinOutNext[i] = cfg[i].pinFunctionSelect == FUNC_PUSH_PULL && drive[i];
			pinOeNext[i] = cfg[i].pinFunctionSelect == FUNC_PUSH_PULL ||
				(cfg[i].pinFunctionSelect == FUNC_OPEN_DRAIN && !drive[i]);
		end
	end

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pinOut <= '0;
			pinOe <= '0;
			pullUpEnable <= '0;
			supplyTwoSelect <= '0;
		end else begin
			pinOut <= pinOutNext;
			pinOe <= pinOeNext;
			for (int i = 0; i < 16; i++) begin
				pullUpEnable[i] <= cfg[i].pinFunctionSelect == FUNC_OPEN_DRAIN &&
					!cfg[i].polaritySupplySelect;
				supplyTwoSelect[i] <= cfg[i].polaritySupplySelect;
			end
		end
	end

	// ----------------------------------------
	// System signals and interrupt
	// ----------------------------------------
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			wakeUp <= 1'b0;
			seqWaitRelease <= 1'b0;
			interruptRequestN <= 1'b1;
		end else begin
			wakeUp <= |(rise & wakeable);
			seqWaitRelease <= seqWaitRequest & rise[`PORT_SEQ_WAIT] &
				isInput[`PORT_SEQ_WAIT];
			interruptRequestN <= ~|(eventNext & ~maskReg);
		end
	end

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	// Read mux and address decode
	always_comb begin
		readData = 32'h0000_0000;
		addrHit = 1'b1;
		if (regIdx >= `IDX_CFG_FIRST && regIdx <= `IDX_CFG_LAST) begin
			readData = {24'h00_0000, cfgReg[3'(regIdx - `IDX_CFG_FIRST)]};
		end else if (regIdx == `IDX_STATUS) begin
			readData = {16'h0000, statusReg};
		end else if (regIdx == `IDX_EVENT) begin
			readData = {16'h0000, eventReg};
		end else if (regIdx == `IDX_EVENT_CLEAR) begin
			readData = 32'h0000_0000;
		end else if (regIdx == `IDX_MASK) begin
			readData = {16'h0000, maskReg};
		end else if (regIdx == `IDX_OUT_CTRL) begin
			readData = {28'h000_0000, outCtrlReg};
		end else if (regIdx == `IDX_PWM_A) begin
			readData = {24'h00_0000, pwmTargetReg[0]};
		end else if (regIdx == `IDX_PWM_B) begin
			readData = {24'h00_0000, pwmTargetReg[1]};
		end else if (regIdx == `IDX_HW_STAT) begin
			readData = {13'h0000, regulatorNineEnable, regulatorFiveEnable,
				regulatorFourEnable, pwmLevelReg[1], pwmLevelReg[0]};
		end else begin
			addrHit = 1'b0;
		end
	end

	// Answer one cycle after setup; writes land at the access edge
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			apbRsp <= '0;
			cfgReg <= '{default: `CFG_RESET};
			maskReg <= `MASK_RESET;
			outCtrlReg <= '0;
			pwmTargetReg <= '{default: '0};
		end else begin
			apbRsp.pready <= setupPhase;
			apbRsp.pslverr <= setupPhase & ~addrHit;
			apbRsp.prdata <= (setupPhase && !apbReq.pwrite) ? readData : 32'h0000_0000;
			if (wrEn && regIdx >= `IDX_CFG_FIRST && regIdx <= `IDX_CFG_LAST) begin
				cfgReg[3'(regIdx - `IDX_CFG_FIRST)] <= apbReq.pwdata[7:0];
			end else if (wrEn && regIdx == `IDX_MASK) begin
				maskReg <= apbReq.pwdata[15:0];
			end else if (wrEn && regIdx == `IDX_OUT_CTRL) begin
				outCtrlReg <= apbReq.pwdata[3:0];
			end else if (wrEn && regIdx == `IDX_PWM_A) begin
				pwmTargetReg[0] <= apbReq.pwdata[7:0];
			end else if (wrEn && regIdx == `IDX_PWM_B) begin
				pwmTargetReg[1] <= apbReq.pwdata[7:0];
			end
		end
	end

endmodule
`default_nettype wire

// >>> gpio_extender_regs.svh
`ifndef GPIO_EXTENDER_REGS_SVH
`define GPIO_EXTENDER_REGS_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define CLK_MHZ 100
`define CLK_KHZ 100000
`define REG_MIN_ON_US 100
`define RAMP_STEP_MS 32
`define DEBOUNCE_US 10
`define DEBOUNCE_CYCLES (`DEBOUNCE_US * `CLK_MHZ)

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define IDX_CFG_FIRST 6'h15
`define IDX_CFG_LAST 6'h1C
`define IDX_STATUS 6'h30
`define IDX_EVENT 6'h31
`define IDX_EVENT_CLEAR 6'h32
`define IDX_MASK 6'h33
`define IDX_OUT_CTRL 6'h34
`define IDX_PWM_A 6'h35
`define IDX_PWM_B 6'h36
`define IDX_HW_STAT 6'h37

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define OUT_CTRL_FLASH_LSB 0
`define OUT_CTRL_PWM_LSB 2
`define CFG_RESET 8'h00
`define MASK_RESET 16'hFFFF
`define WAKE_PORTS 16'hEFF9
`define PORT_REG_FOUR 1
`define PORT_REG_FIVE 2
`define PORT_SEQ_WAIT 10
`define PORT_FLASH_LO 10
`define PORT_REG_NINE 12
`define PORT_PWM_LO 14

`endif

// >>> gpio_extender_pkg.sv
package gpio_extender_pkg;

	// ----------------------------------------
	// Pin function, port nibble, regulator FSM
	// ----------------------------------------
	typedef enum logic [1:0] {
		FUNC_ALT = 2'b00,
		FUNC_INPUT = 2'b01,
		FUNC_OPEN_DRAIN = 2'b10,
		FUNC_PUSH_PULL = 2'b11
	} pinFunc_t;

	typedef struct packed {
		logic levelDebounceSelect;
		logic polaritySupplySelect;
		pinFunc_t pinFunctionSelect;
	} portCfg_t;

	typedef enum logic [2:0] {
		REG_OFF = 3'b001,
		REG_MIN = 3'b010,
		REG_ON = 3'b100
	} regState_t;

	// ----------------------------------------
	// APB carriers
	// ----------------------------------------
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] pwdata;
	} apbReq_t;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} apbRsp_t;

endpackage

// >>> board_model.sv
`timescale 1ns/1ns
`default_nettype none

module board_model (
	// Board levels
	input wire logic [15:0] level,
	// Device pin drive
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] pullUpEnable,
	// Resolved pins
	output logic [15:0] pinIn
);
	// Driven pins win, undriven pins go to the pull-up if enabled, else to the board level
	assign pinIn = (pinOe & pinOut) | (~pinOe & pullUpEnable) |
		(~pinOe & ~pullUpEnable & level);
endmodule

`default_nettype wire

// >>> gpio_extender_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module gpio_extender_monitor #(
	parameter int unsigned REG_MIN_ON_CYCLES = 10000
) (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// Register bus
	input wire gpio_extender_pkg::apbReq_t apbReq,
	input wire gpio_extender_pkg::apbRsp_t apbRsp,
	// Pins
	input wire logic [15:0] pinOut,
	input wire logic [15:0] pinOe,
	input wire logic [15:0] pullUpEnable,
	input wire logic [15:0] supplyTwoSelect,
	// System side
	input wire logic seqWaitRequest,
	input wire logic seqWaitRelease,
	input wire logic wakeUp,
	input wire logic regulatorFourEnable,
	input wire logic regulatorNineEnable,
	input wire logic interruptRequestN
);
	import gpio_extender_pkg::*;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);
	logic [31:0] onCnt;
	// ----
	// Assertions
	// ----
	// Counts how long regulator nine has been on
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			onCnt <= '0;
		end else begin
			onCnt <= regulatorNineEnable ? onCnt + 32'h0000_0001 : '0;
		end
	end
	chk_ready_after_setup: assert property (apbReq.psel && !apbReq.penable |=> apbRsp.pready)
		else $error("pready missing after setup");
	chk_ready_in_access: assert property (apbRsp.pready |->
		apbReq.psel && apbReq.penable && !$past(apbReq.penable)) else $error("pready outside access");
	chk_err_with_ready: assert property (apbRsp.pslverr |-> apbRsp.pready)
		else $error("pslverr without pready");
	chk_high_needs_drive: assert property ((pinOut & ~pinOe) == 16'h0000)
		else $error("pin high while not driven");
	chk_pull_supply_one: assert property ((pullUpEnable & supplyTwoSelect) == 16'h0000)
		else $error("pull-up on supply two");
	chk_wake_one_cycle: assert property (wakeUp |=> !wakeUp)
		else $error("wake-up longer than a cycle");
	chk_release_cause: assert property (seqWaitRelease |-> $past(seqWaitRequest))
		else $error("release without wait request");
	chk_reg_min_on: assert property ($fell(regulatorNineEnable) |-> onCnt >= REG_MIN_ON_CYCLES)
		else $error("regulator nine on too briefly");
	chk_reg_four_hold: assert property ($rose(regulatorFourEnable) |=> regulatorFourEnable[*8])
		else $error("regulator four dropped early");
	chk_irq_sticky: assert property (!interruptRequestN && !apbReq.psel
		&& !$past(apbReq.psel) |=> !interruptRequestN)
		else $error("interrupt dropped without access");
	cover property (wakeUp);
	cover property ($fell(regulatorNineEnable));
	cover property (seqWaitRelease);
endmodule

bind gpio_extender gpio_extender_monitor #(.REG_MIN_ON_CYCLES(REG_MIN_ON_CYCLES)) i_mon (
	.sys_clk(sys_clk), .reset(reset), .apbReq(apbReq), .apbRsp(apbRsp), .pinOut(pinOut),
	.pinOe(pinOe), .pullUpEnable(pullUpEnable), .supplyTwoSelect(supplyTwoSelect),
	.seqWaitRequest(seqWaitRequest), .seqWaitRelease(seqWaitRelease), .wakeUp(wakeUp),
	.regulatorFourEnable(regulatorFourEnable), .regulatorNineEnable(regulatorNineEnable),
	.interruptRequestN(interruptRequestN));

`default_nettype wire

// >>> gpio_extender_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin nTests++; if ((g) !== (e)) begin fails++; \
	$display("Error at %0t: got %h exp %h", $time, g, e); end end

module gpio_extender_bench;
	import gpio_extender_pkg::*;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	logic sys_clk, reset, ana, flash, seqReq, rel, wake, reg4, reg5, reg9, irqN;
	apbReq_t req;
	apbRsp_t rsp;
	logic [15:0] lvl, pinIn, pinOut, pinOe, pullUp, supTwo;
	logic [32:0] expQ[$], mskQ[$], gotV, expV;
	logic [31:0] seed;
	logic [7:0] rAddr[3] = '{8'h54, 8'h58, 8'h6C};
	logic [7:0] rVal[3] = '{8'h10, 8'h01, 8'h01};
	int rPin[3] = '{1, 2, 12};
	logic [7:0] oCfg[3] = '{8'hB0, 8'h20, 8'hE0};
	logic [3:0] oExp[3] = '{4'hC, 4'h6, 4'h1};
	int fails = 0, nTests = 0, wakes = 0, rels = 0;

	gpio_extender #(.REG_MIN_ON_CYCLES(20), .RAMP_STEP_CYCLES(16)) i_dut (
		.sys_clk(sys_clk), .reset(reset), .apbReq(req), .apbRsp(rsp), .pinIn(pinIn),
		.pinOut(pinOut), .pinOe(pinOe), .pullUpEnable(pullUp), .supplyTwoSelect(supTwo),
		.altLevel(16'h0000), .analogBThresholdCross(ana), .rtcFlash(flash),
		.seqWaitRequest(seqReq), .seqWaitRelease(rel), .wakeUp(wake),
		.regulatorFourEnable(reg4), .regulatorFiveEnable(reg5),
		.regulatorNineEnable(reg9), .interruptRequestN(irqN));
	board_model i_board (.level(lvl), .pinOut(pinOut), .pinOe(pinOe), .pullUpEnable(pullUp),
		.pinIn(pinIn));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wt(input int n);
		repeat (n) @(posedge sys_clk);
	endtask

	// One APB transfer, held until pready is seen
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		req <= '{1'b1, 1'b0, w, a, d};
		@(posedge sys_clk);
		req.penable <= 1'b1;
		do @(posedge sys_clk); while (rsp.pready !== 1'b1);
		req <= '0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [32:0] e, input logic [32:0] m);
		expQ.push_back(e & m);
		mskQ.push_back(m);
		apb(1'b0, a, 32'h0000_0000);
	endtask

	task automatic endOfTest();
		$display("checks %0d mismatches %0d", nTests, fails);
		if (fails == 0 && nTests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// Read answers against the oldest note; pulse counters
	always @(posedge sys_clk) begin
		if (req.psel && req.penable && !req.pwrite && rsp.pready === 1'b1) begin
			gotV = {rsp.pslverr, rsp.prdata} & mskQ.pop_front();
			expV = expQ.pop_front();
			`CHK(gotV, expV)
		end
		if (wake === 1'b1) wakes++;
		if (rel === 1'b1) rels++;
	end

	// Watchdog
	initial begin
		wt(6000);
		fails++;
		endOfTest();
	end

	// Main sequence
	initial begin
		req = '0; reset = 1'b1; lvl = 16'hFFFF; ana = 1'b0; flash = 1'b0; seqReq = 1'b0;
		seed = 32'h696c_ef83;
		wt(16);
		reset <= 1'b0;
		rd(8'hCC, 33'h0_0000_FFFF, ALL);
		rd(8'h54, 33'h0, ALL);
		rd(8'hFC, 33'h1_0000_0000, ALL);
		rd(8'hC8, 33'h0, ALL);
		rd(8'hC4, 33'h0, ALL);
		$display("reset and map done");
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, rAddr[k], {24'h0, rVal[k]});
			lvl[rPin[k]] <= 1'b0;
			wt(6);
			rd(8'hDC, 33'h1 << (16 + k), 33'h1 << (16 + k));
			`CHK({reg9, reg5, reg4}, 3'b001 << k)
			lvl[rPin[k]] <= 1'b1;
			wt(4);
			rd(8'hDC, 33'h1 << (16 + k), 33'h1 << (16 + k));
			wt(40);
			rd(8'hDC, 33'h0, 33'h1 << (16 + k));
		end
		$display("regulators done");
		apb(1'b1, 8'h54, 32'h0000_0001);
		wt(4);
		apb(1'b1, 8'hC8, 32'h0000_FFFF);
		lvl[0] <= 1'b0;
		wt(6);
		rd(8'hC4, 33'h1, 33'h3);
		`CHK(irqN, 1'b1)
		apb(1'b1, 8'hCC, 32'h0000_FFFE);
		wt(2);
		`CHK(irqN, 1'b0)
		apb(1'b1, 8'hC8, 32'h0000_0001);
		wt(2);
		`CHK(irqN, 1'b1)
		`CHK(wakes, 0)
		ana <= 1'b1;
		wt(1);
		ana <= 1'b0;
		wt(2);
		rd(8'hC4, 33'h2, 33'h3);
		$display("events done");
		for (int k = 0; k < 3; k++) begin
			apb(1'b1, 8'h54, {24'h0, oCfg[k]});
			wt(3);
			`CHK({pinOut[1], pinOe[1], pullUp[1], supTwo[1]}, oExp[k])
		end
		apb(1'b1, 8'h68, 32'h0000_0001);
		seqReq <= 1'b1;
		lvl[10] <= 1'b0;
		wt(8);
		`CHK(rels, 1)
		seqReq <= 1'b0;
		apb(1'b1, 8'h68, 32'h0000_000B);
		apb(1'b1, 8'hD0, 32'h0000_0001);
		for (int f = 0; f < 2; f++) begin
			flash <= f[0];
			wt(5);
			`CHK(pinOut[10], f[0])
		end
		$display("outputs done");
		lvl[3] <= 1'b0;
		apb(1'b1, 8'h58, 32'h0000_00D0);
		apb(1'b1, 8'hC8, 32'h0000_FFFF);
		lvl[3] <= 1'b1;
		wt(500);
		rd(8'hC4, 33'h0, 33'h8);
		wt(600);
		rd(8'hC4, 33'h8, 33'h8);
		`CHK(wakes, 1)
		$display("debounce done");
		apb(1'b1, 8'hD0, 32'h0000_000C);
		apb(1'b1, 8'hD4, 32'h0000_0004);
		apb(1'b1, 8'hD8, 32'h0000_0004);
		rd(8'hDC, 33'h0, 33'hFCFC);
		wt(90);
		rd(8'hDC, 33'h404, 33'hFFFF);
		for (int i = 0; i < 8; i++) begin
			seed = lfsr(seed);
			apb(1'b1, 8'h54 + 8'(i * 4), seed);
			rd(8'h54 + 8'(i * 4), {25'h0, seed[7:0]}, ALL);
		end
		$display("pwm and config done");
		wt(4);
		endOfTest();
	end
endmodule

`default_nettype wire
